// ---- design/mmd_decoder.sv ----
`timescale 1ns/1ps
// Function
// - After reset the nonvolatile array also answers at address zero.
// - Clearing bit 0 of the zero select register puts SRAM at zero.
// - Multi-byte data little endian: least significant byte at lowest address.
// - Bank 0 from 0x90000 to 0x9F700; top 1k half-words are boot page.
// - Bank 1 spans 0x80000 to 0x90000, 32k half-words, all user space.
// - Nonvolatile array is divided into 512-byte pages.
// - A 32-bit fetch from the 16-bit array takes two accesses.
// - Array keeps up with 41.78 MHz half-word and 20.89 MHz word fetches.
// - SRAM is 8 kB as 2k 32-bit words, one-cycle word access.
// - All peripheral registers decode into the top two address pages.
// - System bus accesses take one cycle, peripheral bus accesses two.
// - Interrupt, system control, array control and GPIO on the system bus; timers and other blocks on peripheral bus.
// - Interrupt controller decodes from 0xFFFF0000 with one-cycle access.
// - Zero select and reset control at 0xFFFF0200, select byte at 0x0220.
// - Timers decode from 0xFFFF0300 with two-cycle access.
module mmd_decoder
  import mmd_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        core_req,
  output logic             core_ready,
  input  wire logic [31:0] core_addr,
  input  wire logic        core_write,
  input  wire logic [1:0]  core_size,
  input  wire logic [31:0] core_wdata,
  output logic             core_done,
  output logic      [31:0] core_rdata,
  output logic             core_err,
  output logic             sys_sel,
  output logic             per_sel,
  output logic             per_enable,
  output logic      [31:0] bus_addr,
  output logic             bus_write,
  output logic      [31:0] bus_wdata,
  output logic      [3:0]  bus_strb,
  input  wire logic [31:0] sys_rdata,
  input  wire logic [31:0] per_rdata
);

  mmd_state_e  state_ff, nxt_state;
  mmd_tgt_e    tgt;
  logic        accept, bad_align, finish, fin_err;
  logic [31:0] raw;
  logic [31:0] addr_ff, wdata_ff;
  logic        write_ff, done_ff, err_ff;
  logic [1:0]  size_ff;
  logic [3:0]  strb_ff;
  logic [31:0] rdata_ff;
  logic [7:0]  zero_sel_ff;
  logic [31:0] sram_rdata, nv_rdata;
  logic        nv_done, nv_refused;

  // One access at a time; a new one may be taken in the cycle its answer shows.
  assign core_ready = (state_ff == ST_IDLE);
  assign accept     = core_req && core_ready;

  // Unaligned words and halves are refused rather than rotated.
  assign bad_align = ((core_size == SZ_WORD) && (core_addr[1:0] != 2'b00)) ||
                     ((core_size == SZ_HALF) && core_addr[0]) ||
                     (core_size == 2'b11);

  // Address decode of the incoming request.
  always_comb begin
    tgt = T_NONE;
    // The SRAM home lies inside the zero window, so it is tested first or it would be hidden by the mirror.
    if ((core_addr >= SRAM_BASE) && (core_addr < SRAM_BASE + SRAM_BYTES)) begin
      tgt = T_SRAM;
    end else if (core_addr < NV_BYTES) begin
      if (zero_sel_ff[ZERO_SEL_NV]) begin
        tgt = T_NV;
      end else if (core_addr < SRAM_BYTES) begin
        tgt = T_SRAM;
      end
    end else if ((core_addr >= NV_BASE) && (core_addr < NV_BASE + NV_BYTES)) begin
      tgt = T_NV;
    end else if ((core_addr[31:16] == MMR_HI) && (core_addr[15:12] == 4'h0)) begin
      case (core_addr[11:8])
        BLK_IRQ, BLK_FIQ: begin
          tgt = T_SYS;
        end
        BLK_SYSCTL: begin
          tgt = (core_addr[15:2] == ZERO_SEL_OFF[15:2]) ? T_REG : T_SYS;
        end
        BLK_TIMER: begin
          tgt = T_PER;
        end
        BLK_GPIO, BLK_NVCTL: begin
          tgt = T_SYS;
        end
        default: begin
          tgt = T_PER;
        end
      endcase
    end
    // Holes in the register space are not trapped one by one; they reach the buses.
    if (bad_align) begin
      tgt = T_NONE;
    end
  end

  // Access state machine.
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (accept) begin
          case (tgt)
            T_SRAM:  nxt_state = ST_SRAM;
            T_NV:    nxt_state = ST_NV;
            T_SYS:   nxt_state = ST_SYS;
            T_REG:   nxt_state = ST_REG;
            T_PER:   nxt_state = ST_PER_SETUP;
            default: nxt_state = ST_IDLE;
          endcase
        end
      end
      ST_NV: begin
        if (nv_done) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_PER_SETUP: begin
        nxt_state = ST_PER_ACCESS;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Request capture; write data is put on its lanes here.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      addr_ff  <= 32'h00000000;
      wdata_ff <= 32'h00000000;
      write_ff <= 1'b0;
      size_ff  <= SZ_BYTE;
      strb_ff  <= 4'h0;
    end else if (accept) begin
      addr_ff  <= core_addr;
      wdata_ff <= to_lanes(core_wdata, core_addr[1:0]);
      write_ff <= core_write;
      size_ff  <= core_size;
      strb_ff  <= lane_strb(core_addr[1:0], core_size);
    end
  end

  assign bus_addr   = addr_ff;
  assign bus_write  = write_ff;
  assign bus_wdata  = wdata_ff;
  assign bus_strb   = strb_ff;
  assign sys_sel    = (state_ff == ST_SYS);
  assign per_sel    = (state_ff == ST_PER_SETUP) || (state_ff == ST_PER_ACCESS);
  assign per_enable = (state_ff == ST_PER_ACCESS);

  // Zero select register; resets with the array at address zero.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      zero_sel_ff <= ZERO_SEL_RST;
    end else if ((state_ff == ST_REG) && write_ff && strb_ff[0]) begin
      zero_sel_ff <= wdata_ff[7:0];
    end
  end

  mmd_sram #(
    .WORDS (32'(SRAM_BYTES) / 4),
    .AW    (SRAM_AW)
  ) u_sram (
    .clk   (clk),
    .we    ((state_ff == ST_SRAM) && write_ff),
    .idx   (addr_ff[SRAM_AW+1:2]),
    .strb  (strb_ff),
    .wdata (wdata_ff),
    .rdata (sram_rdata)
  );

  mmd_nv_array #(
    .HALF_WORDS (65536),
    .CYC        (NV_HALF_CYC)
  ) u_nv (
    .clk     (clk),
    .arst_n  (arst_n),
    .start   (accept && (tgt == T_NV)),
    .write   (core_write),
    .wide    (core_size == SZ_WORD),
    .off     (core_addr[16:0]),
    .strb    (lane_strb(core_addr[1:0], core_size)),
    .wdata   (to_lanes(core_wdata, core_addr[1:0])),
    .done    (nv_done),
    .refused (nv_refused),
    .rdata   (nv_rdata)
  );

  // Answer source for the finishing access.
  always_comb begin
    finish  = 1'b0;
    fin_err = 1'b0;
    raw     = 32'h00000000;
    case (state_ff)
      ST_IDLE: begin
        finish  = accept && (tgt == T_NONE);
        fin_err = 1'b1;
      end
      ST_SRAM: begin
        finish = 1'b1;
        raw    = sram_rdata;
      end
      ST_NV: begin
        finish  = nv_done;
        fin_err = nv_refused;
        raw     = nv_rdata;
      end
      ST_SYS: begin
        finish = 1'b1;
        raw    = sys_rdata;
      end
      ST_REG: begin
        finish = 1'b1;
        raw    = {24'h000000, zero_sel_ff};
      end
      ST_PER_ACCESS: begin
        finish = 1'b1;
        raw    = per_rdata;
      end
      default: begin
        finish = 1'b0;
      end
    endcase
  end

  // Registered answer, one-cycle done pulse.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      done_ff  <= 1'b0;
      err_ff   <= 1'b0;
      rdata_ff <= 32'h00000000;
    end else begin
      done_ff <= finish;
      if (finish) begin
        err_ff   <= fin_err;
        rdata_ff <= (fin_err || write_ff) ? 32'h00000000 : from_lanes(raw, addr_ff[1:0], size_ff);
      end
    end
  end

  assign core_done  = done_ff;
  assign core_err   = err_ff;
  assign core_rdata = rdata_ff;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  property p_reset_nv_zero;
    $past(!arst_n) |-> zero_sel_ff[ZERO_SEL_NV];
  endproperty
  a_reset_nv_zero: assert property (p_reset_nv_zero) else $error("array not at zero after reset");

  property p_zero_sram;
    accept && (core_addr < SRAM_BYTES) && !bad_align && !zero_sel_ff[ZERO_SEL_NV]
      |=> (state_ff == ST_SRAM) ##1 core_done;
  endproperty
  a_zero_sram: assert property (p_zero_sram) else $error("sram not mapped at zero");

  property p_zero_nv;
    accept && (core_addr < SRAM_BASE) && !bad_align && zero_sel_ff[ZERO_SEL_NV]
      |=> (state_ff == ST_NV);
  endproperty
  a_zero_nv: assert property (p_zero_nv) else $error("array not mapped at zero");

  property p_sys_one;
    accept && (tgt == T_SYS) |=> sys_sel && !per_sel ##1 !sys_sel && core_done;
  endproperty
  a_sys_one: assert property (p_sys_one) else $error("system bus access not one cycle");

  property p_per_two;
    accept && (tgt == T_PER) |=> (per_sel && !per_enable) ##1 (per_sel && per_enable) ##1 (!per_sel && core_done);
  endproperty
  a_per_two: assert property (p_per_two) else $error("peripheral access not two cycles");

  property p_irq_sys;
    accept && !bad_align && (core_addr[31:8] == 24'hffff00) |=> sys_sel;
  endproperty
  a_irq_sys: assert property (p_irq_sys) else $error("interrupt block not on system bus");

  property p_timer_per;
    accept && !bad_align && (core_addr[31:8] == 24'hffff03) |=> per_sel ##1 per_enable;
  endproperty
  a_timer_per: assert property (p_timer_per) else $error("timer block not on peripheral bus");

  property p_byte_lane;
    accept && (tgt != T_NONE) && (core_size == SZ_BYTE) && (core_addr[1:0] == 2'b11)
      |=> (bus_strb == 4'h8) && (bus_wdata[31:24] == $past(core_wdata[7:0]));
  endproperty
  a_byte_lane: assert property (p_byte_lane) else $error("byte lane wrong");

  property p_zero_sel_wr;
    (state_ff == ST_REG) && write_ff && strb_ff[0] |=> (zero_sel_ff == $past(wdata_ff[7:0]));
  endproperty
  a_zero_sel_wr: assert property (p_zero_sel_wr) else $error("zero select not written");

  c_sys: cover property (accept && (tgt == T_SYS));
  c_per: cover property (accept && (tgt == T_PER) ##3 core_done);
  c_nv_word: cover property (accept && (tgt == T_NV) && (core_size == SZ_WORD));
  c_remap: cover property ((state_ff == ST_REG) && write_ff ##1 !zero_sel_ff[ZERO_SEL_NV]);

endmodule // mmd_decoder

// ---- design/mmd_nv_array.sv ----
`timescale 1ns/1ps
module mmd_nv_array
  import mmd_pkg::*;
#(
  parameter int HALF_WORDS = 65536,
  parameter int CYC        = NV_HALF_CYC
) (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        start,
  input  wire logic        write,
  input  wire logic        wide,
  input  wire logic [16:0] off,
  input  wire logic [3:0]  strb,
  input  wire logic [31:0] wdata,
  output logic             done,
  output logic             refused,
  output logic      [31:0] rdata
);

  localparam int NV_WIDE_LAT   = 2 * CYC + 1;
  localparam int NV_NARROW_LAT = CYC + 1;

  logic [15:0] mem [HALF_WORDS];
  logic        busy_ff, hi_ff, wide_ff, write_ff, ref_ff, done_ff;
  logic [3:0]  cnt_ff, strb_ff;
  logic [15:0] idx_ff;
  logic [31:0] wdata_ff, data_ff;
  logic        step, wr_en;
  logic [1:0]  half_strb;
  logic [15:0] half_wd;

  // One half-word per CYC cycles keeps the array within its fetch rate.
  assign step      = busy_ff && (cnt_ff == 4'(CYC - 1));
  assign wr_en     = step && write_ff && !ref_ff;
  assign half_strb = hi_ff ? strb_ff[3:2] : strb_ff[1:0];
  assign half_wd   = hi_ff ? wdata_ff[31:16] : wdata_ff[15:0];

  // Sequencer: a word takes two array accesses, low half first.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_ff  <= 1'b0;
      hi_ff    <= 1'b0;
      wide_ff  <= 1'b0;
      write_ff <= 1'b0;
      ref_ff   <= 1'b0;
      done_ff  <= 1'b0;
      cnt_ff   <= 4'h0;
      strb_ff  <= 4'h0;
      idx_ff   <= 16'h0000;
      wdata_ff <= 32'h00000000;
      data_ff  <= 32'h00000000;
    end else begin
      done_ff <= 1'b0;
      if (start) begin
        busy_ff  <= 1'b1;
        cnt_ff   <= 4'h0;
        idx_ff   <= off[16:1];
        hi_ff    <= off[1];
        wide_ff  <= wide;
        write_ff <= write;
        strb_ff  <= strb;
        wdata_ff <= wdata;
        data_ff  <= 32'h00000000;
        // Boot page is factory space, so user writes there are refused.
        ref_ff   <= write && (off[16:9] >= NV_BOOT_PAGE);
      end else if (step) begin
        data_ff[{hi_ff, 4'h0} +: 16] <= mem[idx_ff];
        cnt_ff <= 4'h0;
        if (wide_ff && !hi_ff) begin
          hi_ff  <= 1'b1;
          idx_ff <= idx_ff + 16'h0001;
        end else begin
          busy_ff <= 1'b0;
          done_ff <= 1'b1;
        end
      end else if (busy_ff) begin
        cnt_ff <= cnt_ff + 4'h1;
      end
    end
  end

  // Array write port, byte lanes of the current half.
  always_ff @(posedge clk) begin
    if (wr_en && half_strb[0]) begin
      mem[idx_ff][7:0] <= half_wd[7:0];
    end
    if (wr_en && half_strb[1]) begin
      mem[idx_ff][15:8] <= half_wd[15:8];
    end
  end

  assign done    = done_ff;
  assign refused = ref_ff;
  assign rdata   = data_ff;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  property p_wide_two_halves;
    start && wide |-> ##NV_WIDE_LAT done_ff;
  endproperty
  a_wide_two_halves: assert property (p_wide_two_halves) else $error("word fetch not two accesses");

  property p_narrow_one_half;
    start && !wide |-> ##NV_NARROW_LAT done_ff;
  endproperty
  a_narrow_one_half: assert property (p_narrow_one_half) else $error("narrow access latency wrong");

  property p_boot_protect;
    wr_en |-> (idx_ff[15:8] < NV_BOOT_PAGE);
  endproperty
  a_boot_protect: assert property (p_boot_protect) else $error("write reached boot page");

endmodule // mmd_nv_array

// ---- design/mmd_pkg.sv ----
package mmd_pkg;

  // Core clock and the array fetch ceilings for half-word and word fetches.
  localparam int unsigned CLK_HZ      = 20_000_000;
  localparam int unsigned NV_HALF_HZ  = 41_780_000;
  localparam int unsigned NV_WORD_HZ  = 20_890_000;
  // Cycles per 16-bit array access; rounded up, so never below one.
  localparam int unsigned NV_HALF_CYC = (CLK_HZ + NV_HALF_HZ - 1) / NV_HALF_HZ;

  // Memory layout.
  localparam logic [31:0] NV_BASE       = 32'h0008_0000;
  localparam logic [31:0] NV_BANK0_BASE = 32'h0009_0000;
  localparam logic [31:0] NV_USER_TOP   = 32'h0009_f700;
  localparam logic [31:0] NV_BOOT_BASE  = 32'h0009_f800;
  localparam logic [31:0] NV_BYTES      = 32'h0002_0000;
  localparam logic [31:0] NV_PAGE_BYTES = 32'h0000_0200;
  localparam logic [7:0]  NV_BOOT_PAGE  = 8'((NV_BOOT_BASE - NV_BASE) / NV_PAGE_BYTES);
  localparam logic [31:0] SRAM_BASE     = 32'h0001_0000;
  localparam logic [31:0] SRAM_BYTES    = 32'h0000_2000;
  localparam int          SRAM_AW       = 11;

  // Register space in the top two pages.
  localparam logic [15:0] MMR_HI       = 16'hffff;
  localparam logic [3:0]  BLK_IRQ      = 4'h0;
  localparam logic [3:0]  BLK_FIQ      = 4'h1;
  localparam logic [3:0]  BLK_SYSCTL   = 4'h2;
  localparam logic [3:0]  BLK_TIMER    = 4'h3;
  localparam logic [3:0]  BLK_GPIO     = 4'hd;
  localparam logic [3:0]  BLK_NVCTL    = 4'he;
  localparam logic [15:0] ZERO_SEL_OFF = 16'h0220;
  localparam logic [7:0]  ZERO_SEL_RST = 8'h01;
  localparam int          ZERO_SEL_NV  = 0;

  typedef enum logic [1:0] {
    SZ_BYTE = 2'b00,
    SZ_HALF = 2'b01,
    SZ_WORD = 2'b10
  } mmd_size_e;

  typedef enum logic [2:0] {
    T_NONE = 3'b000,
    T_SRAM = 3'b001,
    T_NV   = 3'b010,
    T_SYS  = 3'b011,
    T_PER  = 3'b100,
    T_REG  = 3'b101
  } mmd_tgt_e;

  typedef enum logic [2:0] {
    ST_IDLE       = 3'b000,
    ST_SRAM       = 3'b001,
    ST_NV         = 3'b010,
    ST_SYS        = 3'b011,
    ST_REG        = 3'b100,
    ST_PER_SETUP  = 3'b101,
    ST_PER_ACCESS = 3'b110
  } mmd_state_e;

  // Byte lanes touched by an access, lowest address in lane 0.
  function automatic logic [3:0] lane_strb(input logic [1:0] lo, input logic [1:0] sz);
    case (sz)
      SZ_BYTE: lane_strb = 4'h1 << lo;
      SZ_HALF: lane_strb = 4'h3 << lo;
      default: lane_strb = 4'hf;
    endcase
  endfunction

  // Move a right-aligned value onto its byte lanes.
  function automatic logic [31:0] to_lanes(input logic [31:0] d, input logic [1:0] lo);
    to_lanes = d << {lo, 3'b000};
  endfunction

  // Bring lane data back to a right-aligned, zero-extended value.
  function automatic logic [31:0] from_lanes(input logic [31:0] d, input logic [1:0] lo,
                                             input logic [1:0] sz);
    logic [31:0] t;
    t = d >> {lo, 3'b000};
    case (sz)
      SZ_BYTE: from_lanes = {24'h000000, t[7:0]};
      SZ_HALF: from_lanes = {16'h0000, t[15:0]};
      default: from_lanes = t;
    endcase
  endfunction

endpackage

// ---- design/mmd_sram.sv ----
`timescale 1ns/1ps
module mmd_sram
  import mmd_pkg::*;
#(
  parameter int WORDS = 2048,
  parameter int AW    = 11
) (
  input  wire logic          clk,
  input  wire logic          we,
  input  wire logic [AW-1:0] idx,
  input  wire logic [3:0]    strb,
  input  wire logic [31:0]   wdata,
  output logic      [31:0]   rdata
);

  logic [31:0] mem [WORDS];

  // Full 32-bit width so a word is served in one cycle; strobes pick the lanes.
  always_ff @(posedge clk) begin
    for (int b = 0; b < 4; b++) begin
      if (we && strb[b]) begin
        mem[idx][b*8 +: 8] <= wdata[b*8 +: 8];
      end
    end
  end

  // Read is asynchronous; the decoder registers it.
  assign rdata = mem[idx];

endmodule // mmd_sram

// ---- tb/memory_map_decoder_tb.sv ----
`timescale 1ns/1ps
module memory_map_decoder_tb
  import mmd_pkg::*;
;
  typedef struct {
    logic [31:0] a;
    logic        w;
    logic [1:0]  s;
    logic [31:0] d;
    logic [31:0] r;
    logic        e;
    int          lat;
    int          sc;
    int          pc;
  } mmd_row_s;

  logic        clk;
  logic        arst_n;
  logic        core_req;
  logic        core_ready;
  logic [31:0] core_addr;
  logic        core_write;
  logic [1:0]  core_size;
  logic [31:0] core_wdata;
  logic        core_done;
  logic [31:0] core_rdata;
  logic        core_err;
  logic        sys_sel;
  logic        per_sel;
  logic        per_enable;
  logic [31:0] bus_addr;
  logic        bus_write;
  logic [31:0] bus_wdata;
  logic [3:0]  bus_strb;
  logic [31:0] sys_rdata;
  logic [31:0] per_rdata;
  logic [31:0] last_wdata;
  logic [3:0]  last_strb;
  int          fails;
  int          checks_done;
  logic [31:0] rd;
  logic        er;
  int          lat;
  int          sc;
  int          pc;

  // A count of 3 in sc or pc means that bus is not watched for that row.
  // Register-space rows include holes: 0xffff_0500 goes to the peripheral bus and 0xffff_1000 is refused.
  mmd_row_s rows [30] = '{
    '{32'hffff_0220, 1'b0, SZ_WORD, 32'h0, 32'h0000_0001, 1'b0, 2, 0, 0},
    '{32'h0001_0000, 1'b1, SZ_WORD, 32'h1122_3344, 32'h0, 1'b0, 2, 0, 0},
    '{32'h0001_0003, 1'b1, SZ_BYTE, 32'h0000_00aa, 32'h0, 1'b0, 2, 0, 0},
    '{32'h0001_0001, 1'b0, SZ_BYTE, 32'h0, 32'h0000_0033, 1'b0, 2, 0, 0},
    '{32'h0001_0002, 1'b0, SZ_HALF, 32'h0, 32'h0000_aa22, 1'b0, 2, 0, 0},
    '{32'h0001_1ffc, 1'b1, SZ_WORD, 32'h0f0e_0d0c, 32'h0, 1'b0, 2, 0, 0},
    '{32'h0001_1ffc, 1'b0, SZ_WORD, 32'h0, 32'h0f0e_0d0c, 1'b0, 2, 0, 0},
    '{32'h0008_0000, 1'b1, SZ_HALF, 32'h0000_beef, 32'h0, 1'b0, 3, 3, 0},
    '{32'h0008_0002, 1'b1, SZ_HALF, 32'h0000_cafe, 32'h0, 1'b0, 3, 3, 0},
    '{32'h0008_0000, 1'b0, SZ_WORD, 32'h0, 32'hcafe_beef, 1'b0, 4, 3, 0},
    '{32'h0000_0000, 1'b0, SZ_WORD, 32'h0, 32'hcafe_beef, 1'b0, 4, 3, 0},
    '{32'h0008_fffe, 1'b1, SZ_HALF, 32'h0000_1357, 32'h0, 1'b0, 3, 3, 0},
    '{32'h0008_fffe, 1'b0, SZ_HALF, 32'h0, 32'h0000_1357, 1'b0, 3, 3, 0},
    '{32'h0009_0000, 1'b1, SZ_HALF, 32'h0000_2468, 32'h0, 1'b0, 3, 3, 0},
    '{32'h0009_f6fe, 1'b1, SZ_HALF, 32'h0000_9abc, 32'h0, 1'b0, 3, 3, 0},
    '{32'h0009_0000, 1'b0, SZ_HALF, 32'h0, 32'h0000_2468, 1'b0, 3, 3, 0},
    '{32'h0009_f6fe, 1'b0, SZ_HALF, 32'h0, 32'h0000_9abc, 1'b0, 3, 3, 0},
    '{32'h0009_f800, 1'b1, SZ_HALF, 32'h0000_1111, 32'h0, 1'b1, 3, 0, 0},
    '{32'h0001_f800, 1'b1, SZ_HALF, 32'h0000_1111, 32'h0, 1'b1, 3, 0, 0},
    '{32'h0009_0001, 1'b0, SZ_HALF, 32'h0, 32'h0, 1'b1, 1, 0, 0},
    '{32'hffff_0004, 1'b0, SZ_WORD, 32'h0, 32'h0000_fffb, 1'b0, 2, 1, 0},
    '{32'hffff_0000, 1'b0, SZ_WORD, 32'h0, 32'h0000_ffff, 1'b0, 2, 1, 0},
    '{32'hffff_0d00, 1'b0, SZ_WORD, 32'h0, 32'h0000_f2ff, 1'b0, 2, 1, 0},
    '{32'hffff_0300, 1'b0, SZ_WORD, 32'h0, 32'h0300_ffff, 1'b0, 3, 0, 2},
    '{32'hffff_0500, 1'b0, SZ_WORD, 32'h0, 32'h0500_ffff, 1'b0, 3, 0, 2},
    '{32'hffff_1000, 1'b0, SZ_WORD, 32'h0, 32'h0, 1'b1, 1, 0, 0},
    '{32'h0001_0000, 1'b0, 2'b11, 32'h0, 32'h0, 1'b1, 1, 0, 0},
    '{32'hffff_0220, 1'b1, SZ_BYTE, 32'h0000_0000, 32'h0, 1'b0, 2, 0, 0},
    '{32'h0000_0000, 1'b0, SZ_WORD, 32'h0, 32'haa22_3344, 1'b0, 2, 0, 0},
    '{32'hffff_0220, 1'b0, SZ_WORD, 32'h0, 32'h0, 1'b0, 2, 0, 0}
  };

  mmd_decoder uut (
    .clk(clk), .arst_n(arst_n), .core_req(core_req), .core_ready(core_ready), .core_addr(core_addr),
    .core_write(core_write), .core_size(core_size), .core_wdata(core_wdata), .core_done(core_done),
    .core_rdata(core_rdata), .core_err(core_err), .sys_sel(sys_sel), .per_sel(per_sel),
    .per_enable(per_enable), .bus_addr(bus_addr), .bus_write(bus_write), .bus_wdata(bus_wdata),
    .bus_strb(bus_strb), .sys_rdata(sys_rdata), .per_rdata(per_rdata)
  );

  mmd_bus_slave slave (
    .clk(clk), .sys_sel(sys_sel), .per_sel(per_sel), .per_enable(per_enable), .bus_addr(bus_addr),
    .bus_write(bus_write), .bus_wdata(bus_wdata), .bus_strb(bus_strb), .sys_rdata(sys_rdata),
    .per_rdata(per_rdata), .last_wdata(last_wdata), .last_strb(last_strb)
  );

  // The clock toggles every half period of 25 ns.
  always #25 clk = ~clk;

  // Counts each comparison and reports a mismatch at once.
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic close_out();
    $display("checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // One core access; the decoder is idle on entry, so the request is taken at the next edge.
  task automatic access(input logic [31:0] a, input logic w, input logic [1:0] s, input logic [31:0] d);
    @(posedge clk);
    core_req   <= 1'b1;
    core_addr  <= a;
    core_write <= w;
    core_size  <= s;
    core_wdata <= d;
    @(posedge clk);
    core_req <= 1'b0;
    lat = 1;
    sc  = 0;
    pc  = 0;
    #1;
    // A hung answer is cut short after 20 cycles.
    while (core_done !== 1'b1 && lat < 20) begin
      sc += int'(sys_sel === 1'b1);
      pc += int'(per_sel === 1'b1);
      @(posedge clk);
      #1;
      lat++;
    end
    if (core_done !== 1'b1) begin
      fails++;
      $display("unexpected timeout at address %h", a);
      close_out();
    end
    rd = core_rdata;
    er = core_err;
  endtask

  initial begin
    clk = 1'b0;
    arst_n = 1'b0;
    core_req = 1'b0;
    core_addr = 32'h0;
    core_write = 1'b0;
    core_size = 2'b00;
    core_wdata = 32'h0;
    fails = 0;
    checks_done = 0;
    repeat (3) @(posedge clk);
    check("ready in reset", {31'h0, core_ready}, 32'h1);
    arst_n <= 1'b1;
    foreach (rows[i]) begin
      access(rows[i].a, rows[i].w, rows[i].s, rows[i].d);
      check("rdata", rd, rows[i].r);
      check("err", {31'h0, er}, {31'h0, rows[i].e});
      check("latency", 32'(lat), 32'(rows[i].lat));
      if (rows[i].sc != 3) check("sys cycles", 32'(sc), 32'(rows[i].sc));
      if (rows[i].pc != 3) check("per cycles", 32'(pc), 32'(rows[i].pc));
      $display("row %0d done", i);
    end
    // A byte write on the peripheral bus lands in lane 1 with a two-cycle access.
    access(32'hffff_0301, 1'b1, SZ_BYTE, 32'h0000_005a);
    check("lane data", last_wdata, 32'h0000_5a00);
    check("lane strobe", {28'h0, last_strb}, 32'h2);
    check("per cycles", 32'(pc), 32'h2);
    $display("lane test done");
    // A reset in mid-run brings the array back at address zero.
    @(posedge clk);
    arst_n <= 1'b0;
    @(posedge clk);
    #1;
    check("ready in reset", {31'h0, core_ready}, 32'h1);
    check("done in reset", {31'h0, core_done}, 32'h0);
    @(posedge clk);
    arst_n <= 1'b1;
    access(32'hffff_0220, 1'b0, SZ_WORD, 32'h0);
    check("zero select", rd, 32'h1);
    access(32'h0000_0000, 1'b0, SZ_WORD, 32'h0);
    check("zero mirror", rd, 32'hcafe_beef);
    $display("reset test done");
    close_out();
  end
endmodule // memory_map_decoder_tb

// ---- tb/mmd_bus_slave.sv ----
`timescale 1ns/1ps
// Register-bus slave standing in for every peripheral on the system and peripheral buses.
module mmd_bus_slave (
  input  wire logic        clk,
  input  wire logic        sys_sel,
  input  wire logic        per_sel,
  input  wire logic        per_enable,
  input  wire logic [31:0] bus_addr,
  input  wire logic        bus_write,
  input  wire logic [31:0] bus_wdata,
  input  wire logic [3:0]  bus_strb,
  output logic      [31:0] sys_rdata,
  output logic      [31:0] per_rdata,
  output logic      [31:0] last_wdata,
  output logic      [3:0]  last_strb
);
  logic [31:0] junk_ff = 32'h5a5a_a5a5;

  // Idle read lines toggle each cycle, so a stale or early sample never passes for an answer.
  always_ff @(posedge clk) begin
    junk_ff <= ~junk_ff;
  end

  // Read data is valid only in the single system cycle or the peripheral enable cycle.
  assign sys_rdata = (sys_sel && !bus_write) ? ~bus_addr : junk_ff;
  assign per_rdata = (per_sel && per_enable && !bus_write) ? {bus_addr[15:0], bus_addr[31:16]} : junk_ff;

  // Writes land at the edge that ends the data cycle of either bus.
  always_ff @(posedge clk) begin
    if (bus_write && (sys_sel || (per_sel && per_enable))) begin
      last_wdata <= bus_wdata;
      last_strb  <= bus_strb;
    end
  end
endmodule // mmd_bus_slave
